// *** plp_port_latches.sv ***
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none

`include "plp_consts.svh"

module plp_port_latches (
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  reset_n_in,
   // CPU access
   input  wire plp_pkg::plp_cpu_req_t cpu_req_in,
   input  wire logic                  bank_we_in,
   input  wire logic                  stop_exec_in,
   input  wire logic                  wake_in,
   input  wire logic                  tmr_div6_in,
   output logic [3:0]                 cpu_rdata_out,
   output logic [1:0]                 bank_out,
   // Chip enable and resets
   input  wire logic                  chip_enable_in,
   output logic                       cpu_reset_out,
   output logic                       osc_stopped_out,
   // Pins
   input  wire plp_pkg::plp_pins_t    pins_in,
   output plp_pkg::plp_pins_t         pins_out,
   output plp_pkg::plp_pins_t         pins_oe_out,
   output logic [3:0]                 output_port_d1_out,
   output logic [3:0]                 open_drain_port_a1_oe_out,
   // Shared functions
   input  wire logic                  so_in,
   input  wire logic                  so_en_in,
   input  wire logic                  sck_out_in,
   input  wire logic                  sck_oe_in,
   input  wire logic                  sda_drive_low_in,
   input  wire logic                  scl_drive_low_in,
   output logic                       serial_data_in_out,
   output logic                       sck_pin_out,
   output logic                       sda_pin_out,
   output logic                       scl_pin_out,
   output logic                       hsync_counter_input_out,
   output logic                       external_timer_irq_out
);
   import plp_pkg::*;

   //****************************************************************
   // State
   //****************************************************************
   typedef struct packed {
      plp_nib_t       lat_a0;
      plp_nib_t       lat_b0;
      plp_nib_t       lat_a1;
      plp_nib_t       lat_b1;
      plp_nib_t       lat_c1;
      plp_nib_t       lat_d1;
      plp_nib_t       lat_a2;
      plp_nib_t       port_a0_bit_direction;
      plp_nib_t       port_b0_bit_direction;
      plp_nib_t       port_b1_bit_direction;
      logic           port_c1_group_direction;
      logic [1:0]     bank;
      plp_osc_state_t osc;
      logic           osc_stop;
      logic           ce_q1;
      logic           ce_q2;
      logic           ce_prev;
      logic           cpu_rst;
      plp_nib_t       rdata;
      plp_pins_t      pin_q1;
      plp_pins_t      pin_q2;
      plp_pins_t      dout;
      plp_pins_t      oe;
      plp_nib_t       od_a1_oe;
      plp_nib_t       d1_out;
      logic           irq;
   } plp_state_t;

   plp_state_t st_r;
   plp_state_t st_nxt;
   logic       tmr_tick;
   logic       ce_rise;

   // Input bits show the pin, output bits the latch
   function automatic plp_nib_t mix_read(input plp_nib_t dir, input plp_nib_t lat, input plp_nib_t pin);
      mix_read = (dir & lat) | (~dir & pin);
   endfunction

   function automatic logic hit(input plp_cpu_req_t r, input logic [1:0] bnk, input logic [6:0] ofs);
      hit = (r.bank == bnk) && (r.addr == ofs);
   endfunction

   //****************************************************************
   // External timer divider
   //****************************************************************
   plp_tmr_div u_tmr_div (
      .mclk_in      (mclk_in),
      .reset_n_in   (reset_n_in),
      .timer_pin_sync_in (st_r.pin_q2.b1[`PLP_BIT_EXT_TMR]),
      .div6_sel_in  (tmr_div6_in),
      .tick_out     (tmr_tick)
   );

   // Edge taken behind both synchroniser flops, so a slow pin cannot race
   assign ce_rise = st_r.ce_q2 && !st_r.ce_prev;

   //****************************************************************
   // Next state
   //****************************************************************
   always_comb begin
      st_nxt         = st_r;
      st_nxt.pin_q1  = pins_in;
      st_nxt.pin_q2  = st_r.pin_q1;
      st_nxt.ce_q1   = chip_enable_in;
      st_nxt.ce_q2   = st_r.ce_q1;
      st_nxt.ce_prev = st_r.ce_q2;
      st_nxt.cpu_rst = ce_rise;
      st_nxt.irq     = tmr_tick;

      // Stop only honoured while chip enable is low
      case (st_r.osc)
         PLP_RUN: begin
            if (stop_exec_in && !st_r.ce_q2) begin
               st_nxt.osc = PLP_STOP;
            end
            // With chip enable high stop is a plain no-operation
         end
         PLP_STOP: begin
            if (wake_in || ce_rise) begin
               st_nxt.osc = PLP_WAKE;
            end
         end
         PLP_WAKE: begin
            st_nxt.osc = PLP_RUN;
         end
         default: begin
            st_nxt.osc = PLP_RUN;
         end
      endcase
      st_nxt.osc_stop = (st_nxt.osc == PLP_STOP);

      // CPU writes
      if (bank_we_in) begin
         st_nxt.bank = cpu_req_in.bank;
      end
      if (cpu_req_in.dm_we) begin
         if (hit(cpu_req_in, `PLP_BANK0, `PLP_DM_OFS_A)) begin
            st_nxt.lat_a0 = cpu_req_in.wdata;
         end
         if (hit(cpu_req_in, `PLP_BANK0, `PLP_DM_OFS_B)) begin
            st_nxt.lat_b0 = cpu_req_in.wdata;
         end
         if (hit(cpu_req_in, `PLP_BANK1, `PLP_DM_OFS_A)) begin
            st_nxt.lat_a1 = cpu_req_in.wdata;
         end
         if (hit(cpu_req_in, `PLP_BANK1, `PLP_DM_OFS_B)) begin
            st_nxt.lat_b1 = cpu_req_in.wdata;
         end
         if (hit(cpu_req_in, `PLP_BANK1, `PLP_DM_OFS_C)) begin
            st_nxt.lat_c1 = cpu_req_in.wdata;
         end
         if (hit(cpu_req_in, `PLP_BANK1, `PLP_DM_OFS_D)) begin
            st_nxt.lat_d1 = cpu_req_in.wdata;
         end
         if (hit(cpu_req_in, `PLP_BANK2, `PLP_DM_OFS_A)) begin
            st_nxt.lat_a2 = cpu_req_in.wdata;
         end
      end
      if (cpu_req_in.rf_we) begin
         case (cpu_req_in.addr)
            `PLP_RF_DIR_B1: st_nxt.port_b1_bit_direction = cpu_req_in.wdata;
            `PLP_RF_DIR_B0: st_nxt.port_b0_bit_direction = cpu_req_in.wdata;
            `PLP_RF_DIR_A0: st_nxt.port_a0_bit_direction = cpu_req_in.wdata;
            `PLP_RF_GRP_C1: st_nxt.port_c1_group_direction = cpu_req_in.wdata[`PLP_BIT_GRP];
            default: begin
            end
         endcase
      end

      // Chip-enable rise or clock stop: bank 0, every I/O port to input
      if (ce_rise || st_r.osc == PLP_STOP) begin
         st_nxt.bank                    = `PLP_BANK_RESET;
         st_nxt.port_a0_bit_direction   = `PLP_DIR_RESET;
         st_nxt.port_b0_bit_direction   = `PLP_DIR_RESET;
         st_nxt.port_b1_bit_direction   = `PLP_DIR_RESET;
         st_nxt.port_c1_group_direction = 1'b0;
      end

      // Read data
      // Input bits lag the wire by two cycles, through the synchroniser
      st_nxt.rdata = 4'h0;
      if (cpu_req_in.rf_we == 1'b0) begin
         if (hit(cpu_req_in, `PLP_BANK0, `PLP_DM_OFS_A)) begin
            st_nxt.rdata = mix_read(st_r.port_a0_bit_direction, st_r.lat_a0, st_r.pin_q2.a0);
         end
         if (hit(cpu_req_in, `PLP_BANK0, `PLP_DM_OFS_B)) begin
            st_nxt.rdata = mix_read(st_r.port_b0_bit_direction, st_r.lat_b0, st_r.pin_q2.b0);
         end
         // Output-only ports read back their latch
         if (hit(cpu_req_in, `PLP_BANK1, `PLP_DM_OFS_A)) begin
            st_nxt.rdata = st_r.lat_a1;
         end
         if (hit(cpu_req_in, `PLP_BANK1, `PLP_DM_OFS_B)) begin
            st_nxt.rdata = mix_read(st_r.port_b1_bit_direction, st_r.lat_b1, st_r.pin_q2.b1);
         end
         if (hit(cpu_req_in, `PLP_BANK1, `PLP_DM_OFS_C)) begin
            st_nxt.rdata = mix_read({4{st_r.port_c1_group_direction}}, st_r.lat_c1, st_r.pin_q2.c1);
         end
         if (hit(cpu_req_in, `PLP_BANK1, `PLP_DM_OFS_D)) begin
            st_nxt.rdata = st_r.lat_d1;
         end
         if (hit(cpu_req_in, `PLP_BANK2, `PLP_DM_OFS_A)) begin
            st_nxt.rdata = mix_read(st_r.port_b1_bit_direction, st_r.lat_a2, st_r.pin_q2.a2);
         end
      end

      // Pin drive
      st_nxt.dout.a0 = st_r.lat_a0;
      st_nxt.dout.b0 = st_r.lat_b0;
      st_nxt.dout.a2 = st_r.lat_a2;
      st_nxt.dout.b1 = st_r.lat_b1;
      st_nxt.dout.c1 = st_r.lat_c1;
      // Port a2 has no word of its own and follows the port b1 directions
      st_nxt.oe.a0   = st_r.port_a0_bit_direction;
      st_nxt.oe.b0   = st_r.port_b0_bit_direction;
      st_nxt.oe.a2   = st_r.port_b1_bit_direction;
      st_nxt.oe.b1   = st_r.port_b1_bit_direction;
      // One group bit steers all four port c1 pins
      st_nxt.oe.c1   = {4{st_r.port_c1_group_direction}};
      // Serial functions override port a0 when enabled
      if (so_en_in) begin
         st_nxt.dout.a0[`PLP_BIT_SO] = so_in;
         st_nxt.oe.a0[`PLP_BIT_SO]   = 1'b1;
      end
      if (sck_oe_in) begin
         st_nxt.dout.a0[`PLP_BIT_SCK] = sck_out_in;
         st_nxt.oe.a0[`PLP_BIT_SCK]   = 1'b1;
      end
      // Two-wire lines only ever pull low
      if (sda_drive_low_in) begin
         st_nxt.dout.a0[`PLP_BIT_SDA] = 1'b0;
         st_nxt.oe.a0[`PLP_BIT_SDA]   = 1'b1;
      end
      if (scl_drive_low_in) begin
         st_nxt.dout.a0[`PLP_BIT_SCL] = 1'b0;
         st_nxt.oe.a0[`PLP_BIT_SCL]   = 1'b1;
      end
      st_nxt.od_a1_oe = ~st_r.lat_a1;
      st_nxt.d1_out   = st_r.lat_d1;
   end

   //****************************************************************
   // Registers
   //****************************************************************
   // Latch reset value is a convenience; software must not rely on it
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_r     <= '0;
         st_r.osc <= PLP_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   //****************************************************************
   // Outputs
   //****************************************************************
   assign cpu_rdata_out             = st_r.rdata;
   assign bank_out                  = st_r.bank;
   assign cpu_reset_out             = st_r.cpu_rst;
   assign osc_stopped_out           = st_r.osc_stop;
   assign pins_out                  = st_r.dout;
   assign pins_oe_out               = st_r.oe;
   assign output_port_d1_out        = st_r.d1_out;
   assign open_drain_port_a1_oe_out = st_r.od_a1_oe;
   assign serial_data_in_out        = st_r.pin_q2.b0[`PLP_BIT_SI];
   assign hsync_counter_input_out   = st_r.pin_q2.b0[`PLP_BIT_HSYNC];
   assign sck_pin_out               = st_r.pin_q2.a0[`PLP_BIT_SCK];
   assign sda_pin_out               = st_r.pin_q2.a0[`PLP_BIT_SDA];
   assign scl_pin_out               = st_r.pin_q2.a0[`PLP_BIT_SCL];
   assign external_timer_irq_out    = st_r.irq;

endmodule // plp_port_latches

`default_nettype wire

// *** plp_consts.svh ***
`ifndef PLP_CONSTS_SVH
`define PLP_CONSTS_SVH

// Register file offsets of the direction words
`define PLP_RF_DIR_B1      7'h35
`define PLP_RF_DIR_B0      7'h36
`define PLP_RF_DIR_A0      7'h37
`define PLP_RF_GRP_C1      7'h27

// Data memory latch offsets within a bank
`define PLP_DM_OFS_A       7'h70
`define PLP_DM_OFS_B       7'h71
`define PLP_DM_OFS_C       7'h72
`define PLP_DM_OFS_D       7'h73

// Banks
`define PLP_BANK0          2'h0
`define PLP_BANK1          2'h1
`define PLP_BANK2          2'h2

// Reset values
`define PLP_DIR_RESET      4'h0
`define PLP_LAT_RESET      4'h0
`define PLP_BANK_RESET     2'h0

// External timer divide ratios
`define PLP_TMR_DIV5       3'h5
`define PLP_TMR_DIV6       3'h6

// Bit positions of shared functions
`define PLP_BIT_SI         0
`define PLP_BIT_SDA        0
`define PLP_BIT_SCL        1
`define PLP_BIT_SCK        2
`define PLP_BIT_SO         3
`define PLP_BIT_HSYNC      3
`define PLP_BIT_EXT_TMR    3
`define PLP_BIT_GRP        0

`endif

// *** plp_pkg.sv ***
`default_nettype none

package plp_pkg;

   typedef logic [3:0] plp_nib_t;

   typedef enum logic [2:0] {
      PLP_RUN  = 3'b001,
      PLP_STOP = 3'b010,
      PLP_WAKE = 3'b100
   } plp_osc_state_t;

   // Port pins grouped per nibble
   typedef struct packed {
      plp_nib_t a0;
      plp_nib_t b0;
      plp_nib_t a2;
      plp_nib_t b1;
      plp_nib_t c1;
   } plp_pins_t;

   // Data memory / register file access from the CPU
   typedef struct packed {
      logic       dm_we;
      logic       rf_we;
      logic [1:0] bank;
      logic [6:0] addr;
      plp_nib_t   wdata;
   } plp_cpu_req_t;

endpackage

`default_nettype wire

// *** plp_tmr_div.sv ***
`timescale 1ns/10ps
`default_nettype none

module plp_tmr_div (
   // Clock and reset
   input  wire logic  mclk_in,
   input  wire logic  reset_n_in,
   // Synchronised timer pin and ratio select
   input  wire logic  timer_pin_sync_in,
   input  wire logic  div6_sel_in,
   // Interrupt request pulse
   output logic       tick_out
);
   import plp_pkg::*;

   typedef struct packed {
      logic       prev;
      logic [2:0] cnt;
      logic       tick;
   } plp_tmr_st_t;

   plp_tmr_st_t st_r;
   plp_tmr_st_t st_nxt;
   logic [2:0]  ratio;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      st_nxt.prev = timer_pin_sync_in;
      ratio       = div6_sel_in ? `PLP_TMR_DIV6 : `PLP_TMR_DIV5;
      // Rising edges counted, one pulse every 5 or 6 of them
      if (timer_pin_sync_in && !st_r.prev) begin
         if (st_r.cnt >= ratio - 3'h1) begin
            st_nxt.cnt  = 3'h0;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick_out = st_r.tick;

endmodule // plp_tmr_div

`default_nettype wire

// *** plp_port_latches_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module plp_port_latches_properties (
   // Clock and reset
   input wire logic                  mclk_in,
   input wire logic                  reset_n_in,
   // CPU side
   input wire plp_pkg::plp_cpu_req_t cpu_req_in,
   input wire logic                  stop_exec_in,
   input wire logic                  chip_enable_in,
   input wire logic [3:0]            cpu_rdata_out,
   input wire logic [1:0]            bank_out,
   input wire logic                  cpu_reset_out,
   input wire logic                  osc_stopped_out,
   // Pin side
   input wire plp_pkg::plp_pins_t    pins_in,
   input wire plp_pkg::plp_pins_t    pins_oe_out,
   input wire logic [3:0]            output_port_d1_out,
   input wire logic [3:0]            open_drain_port_a1_oe_out,
   input wire logic                  serial_data_in_out,
   input wire logic                  external_timer_irq_out
);
   import plp_pkg::*;
   // ****************************************
   // Port checks
   // ****************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   property p_d1_write; cpu_req_in.dm_we && cpu_req_in.bank == 2'h1 && cpu_req_in.addr == 7'h73
      |-> ##2 output_port_d1_out == $past(cpu_req_in.wdata, 2); endproperty
   a_d1_write: assert property (p_d1_write) else $error("port d1 missed its latch write");
   property p_a1_write; cpu_req_in.dm_we && cpu_req_in.bank == 2'h1 && cpu_req_in.addr == 7'h70
      |-> ##2 open_drain_port_a1_oe_out == ~$past(cpu_req_in.wdata, 2); endproperty
   a_a1_write: assert property (p_a1_write) else $error("port a1 pull-down differs from latch");
   property p_ce_edge; $rose(chip_enable_in) |-> ##[2:5] cpu_reset_out; endproperty
   a_ce_edge: assert property (p_ce_edge) else $error("chip enable rise gave no reset");
   property p_rst_pulse; cpu_reset_out |=> !cpu_reset_out; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse longer than one cycle");
   // Bank clears with the pulse, pin drivers one cycle later
   property p_rst_state; cpu_reset_out |-> bank_out == 2'h0 ##1 pins_oe_out == '0; endproperty
   a_rst_state: assert property (p_rst_state) else $error("reset left bank or direction set");
   // Four quiet samples so the synchronised level agrees with the pin
   property p_halt; (!chip_enable_in) [*4] ##0 stop_exec_in |-> ##[1:3] osc_stopped_out; endproperty
   a_halt: assert property (p_halt) else $error("stop with chip enable low did not halt");
   property p_nop; chip_enable_in [*4] ##0 (stop_exec_in && !osc_stopped_out) |=> !osc_stopped_out [*3]; endproperty
   a_nop: assert property (p_nop) else $error("stop with chip enable high halted");
   property p_stop_dir; osc_stopped_out [*3] |-> pins_oe_out.b0 == 4'h0 && pins_oe_out == '0; endproperty
   a_stop_dir: assert property (p_stop_dir) else $error("port driven while clock stopped");
   property p_si; $stable(pins_in.b0[0]) [*4] |-> serial_data_in_out == pins_in.b0[0]; endproperty
   a_si: assert property (p_si) else $error("serial input does not follow its pin");
   property p_unmapped; !cpu_req_in.dm_we && !cpu_req_in.rf_we && cpu_req_in.addr == 7'h00
      |=> cpu_rdata_out == 4'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_irq; external_timer_irq_out |=> !external_timer_irq_out; endproperty
   a_irq: assert property (p_irq) else $error("timer request longer than one cycle");
endmodule // plp_port_latches_properties
bind plp_port_latches plp_port_latches_properties u_props (.mclk_in, .reset_n_in, .cpu_req_in, .stop_exec_in,
   .chip_enable_in, .cpu_rdata_out, .bank_out, .cpu_reset_out, .osc_stopped_out, .pins_in, .pins_oe_out,
   .output_port_d1_out, .open_drain_port_a1_oe_out, .serial_data_in_out, .external_timer_irq_out);
`default_nettype wire

// *** plp_pin_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module plp_pin_model (
   // Device side
   input  wire plp_pkg::plp_pins_t pins_out_in,
   input  wire plp_pkg::plp_pins_t pins_oe_in,
   output plp_pkg::plp_pins_t      pins_in_out,
   // Outside circuit
   input  wire plp_pkg::plp_pins_t ext_drive_in,
   input  wire logic               ce_hold_in,
   output logic                    chip_enable_out
);
   import plp_pkg::*;
   // Driven bits loop back; released bits show the outside circuit, never a stale level
   assign pins_in_out = (pins_oe_in & pins_out_in) | (~pins_oe_in & ext_drive_in);
   assign chip_enable_out = ce_hold_in;
endmodule // plp_pin_model
`default_nettype wire

// *** plp_port_latches_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module plp_port_latches_tb_top;
   import plp_pkg::*;
   // ****************************************
   // Stimulus and scoreboard
   // ****************************************
   logic mclk_in = 1'b0, reset_n_in = 1'b0, bank_we_in = 1'b0, stop_exec_in = 1'b0, wake_in = 1'b0;
   logic tmr_div6_in = 1'b0, ce_hold = 1'b0, so_in = 1'b0, so_en_in = 1'b0, sck_out_in = 1'b0, sck_oe_in = 1'b0;
   logic sda_drive_low_in = 1'b0, scl_drive_low_in = 1'b0, rd_flag = 1'b0, rd_d = 1'b0;
   logic chip_enable_in, cpu_reset_out, osc_stopped_out, serial_data_in_out, sck_pin_out, sda_pin_out;
   logic scl_pin_out, hsync_counter_input_out, external_timer_irq_out;
   logic [3:0] cpu_rdata_out, output_port_d1_out, open_drain_port_a1_oe_out;
   logic [1:0] bank_out;
   logic [31:0] seed = 32'ha23f85ee;
   plp_cpu_req_t cpu_req_in = '0;
   plp_pins_t pins_in, pins_out, pins_oe_out, ext = '0;
   plp_nib_t v [7];
   plp_nib_t expq [$];
   int compares = 0, bad_count = 0, irqs = 0;
   // Bank and address of latches a0, b0, a1, b1, d1, c1, a2
   localparam logic [8:0] LAT [7] = '{9'h070, 9'h071, 9'h0f0, 9'h0f1, 9'h0f3, 9'h0f2, 9'h170};
   plp_port_latches dut (.mclk_in, .reset_n_in, .cpu_req_in, .bank_we_in, .stop_exec_in, .wake_in, .tmr_div6_in,
      .cpu_rdata_out, .bank_out, .chip_enable_in, .cpu_reset_out, .osc_stopped_out, .pins_in, .pins_out,
      .pins_oe_out, .output_port_d1_out, .open_drain_port_a1_oe_out, .so_in, .so_en_in, .sck_out_in, .sck_oe_in,
      .sda_drive_low_in, .scl_drive_low_in, .serial_data_in_out, .sck_pin_out, .sda_pin_out, .scl_pin_out,
      .hsync_counter_input_out, .external_timer_irq_out);
   plp_pin_model u_pins (.pins_out_in(pins_out), .pins_oe_in(pins_oe_out), .pins_in_out(pins_in),
      .ext_drive_in(ext), .ce_hold_in(ce_hold), .chip_enable_out(chip_enable_in));
   always #4 mclk_in = ~mclk_in;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Request stays up until the next call or idle, so back-to-back writes never glitch
   task automatic wr(input logic dm, input logic [8:0] ba, input plp_nib_t d);
      cpu_req_in = '{dm, !dm, ba[8:7], ba[6:0], d};
      rd_flag = 1'b0;
      step(1);
   endtask
   task automatic idle();
      cpu_req_in = '0;
      rd_flag = 1'b0;
      step(1);
   endtask
   task automatic dirs(input plp_nib_t d);
      wr(1'b0, 9'h035, d);
      wr(1'b0, 9'h036, d);
      wr(1'b0, 9'h037, d);
      wr(1'b0, 9'h027, d);
      idle();
   endtask
   task automatic rd_all(input plp_nib_t e [7]);
      for (int i = 0; i < 7; i++) begin
         cpu_req_in = '{1'b0, 1'b0, LAT[i][8:7], LAT[i][6:0], 4'h0};
         expq.push_back(e[i]);
         rd_flag = 1'b1;
         step(1);
      end
      idle();
      step(2);
   endtask
   task automatic strobe(input logic wk);
      stop_exec_in = !wk;
      wake_in = wk;
      step(1);
      stop_exec_in = 1'b0;
      wake_in = 1'b0;
      step(3);
   endtask
   task automatic ce_rise();
      int n = 0;
      ce_hold = 1'b1;
      while (cpu_reset_out !== 1'b1 && n < 10) begin
         step(1);
         n++;
      end
      chk("ce_reset", 4'(cpu_reset_out), 4'h1);
      step(3);
      chk("bank_reset", 4'(bank_out), 4'h0);
      chk("dir_reset", 4'(pins_oe_out === '0), 4'h1);
   endtask
   task automatic tmr(input logic sel, input int edges);
      tmr_div6_in = sel;
      irqs = 0;
      repeat (edges) begin
         ext.b1[3] = 1'b1;
         step(4);
         ext.b1[3] = 1'b0;
         step(4);
      end
      step(6);
      chk("timer_irqs", 4'(irqs), 4'h2);
   endtask
   // Outputs looked at mid-cycle, well clear of the edge that launches them
   always @(negedge mclk_in) begin
      rd_d <= rd_flag;
      irqs <= irqs + int'(external_timer_irq_out === 1'b1);
      if (rd_d)
         chk("rdata", cpu_rdata_out, expq.pop_front());
   end
   initial begin
      #50000;
      bad_count++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge mclk_in);
      #1 reset_n_in = 1'b1;
      step(2);
      chk("d1_reset", output_port_d1_out, 4'h0);
      ce_rise();
      $display("test reset done");
      tmr(1'b0, 10);
      tmr(1'b1, 12);
      $display("test timer done");
      dirs(4'hf);
      foreach (v[i]) v[i] = 4'(rnd());
      for (int i = 0; i < 7; i++) wr(1'b1, LAT[i], v[i]);
      idle();
      step(1);
      chk("a0", pins_out.a0, v[0]);
      chk("b0", pins_out.b0, v[1]);
      chk("a1", open_drain_port_a1_oe_out, ~v[2]);
      chk("b1", pins_out.b1, v[3]);
      chk("d1", output_port_d1_out, v[4]);
      chk("c1", pins_out.c1, v[5]);
      chk("a2", pins_out.a2, v[6]);
      chk("dir_out", 4'(pins_oe_out === '1), 4'h1);
      rd_all(v);
      $display("test output latches done");
      dirs(4'h0);
      ext = 20'(rnd());
      step(5);
      chk("si", 4'(serial_data_in_out), 4'(ext.b0[0]));
      chk("hsync", 4'(hsync_counter_input_out), 4'(ext.b0[3]));
      rd_all('{ext.a0, ext.b0, v[2], ext.b1, v[4], ext.c1, ext.a2});
      $display("test input pins done");
      {so_in, so_en_in, sck_out_in, sck_oe_in, sda_drive_low_in, scl_drive_low_in} = 6'h3f;
      step(5);
      chk("ser_out", pins_out.a0, 4'hc);
      chk("ser_oe", pins_oe_out.a0, 4'hf);
      chk("ser_pins", 4'({sck_pin_out, scl_pin_out, sda_pin_out}), 4'h4);
      {so_in, so_en_in, sck_out_in, sck_oe_in, sda_drive_low_in, scl_drive_low_in} = 6'h00;
      $display("test serial pins done");
      dirs(4'hf);
      cpu_req_in.bank = 2'h2;
      bank_we_in = 1'b1;
      step(1);
      bank_we_in = 1'b0;
      chk("bank_set", 4'(bank_out), 4'h2);
      strobe(1'b0);
      chk("stop_nop", 4'(osc_stopped_out), 4'h0);
      ce_hold = 1'b0;
      step(5);
      strobe(1'b0);
      chk("stop_halt", 4'(osc_stopped_out), 4'h1);
      chk("stop_dir", 4'(pins_oe_out === '0), 4'h1);
      strobe(1'b1);
      chk("wake", 4'(osc_stopped_out), 4'h0);
      strobe(1'b0);
      ce_rise();
      chk("ce_wake", 4'(osc_stopped_out), 4'h0);
      $display("test chip enable done");
      close_out();
   end
endmodule // plp_port_latches_tb_top
`default_nettype wire
